// [logic/pprs_pkg.sv]
package pprs_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] SERIAL4_OFFSET = 12'h000;
    localparam logic [11:0] ROUTE_OFFSET = 12'h004;

    // ****************************************
    // sizes and channel numbering
    // ****************************************
    localparam int ALT_PINS = 3;
    localparam int NUM_CH = 14;
    localparam int NUM_ADC = 3;
    localparam int NUM_TRIG = 9;
    localparam logic [3:0] TRIG_MAX_CODE = 4'h9;
    localparam int CH_SOT = 0;
    localparam int CH_SIN = 1;
    localparam int CH_CTS = 2;
    localparam int CH_RTS = 3;
    localparam int CH_CAN1_TX = 4;
    localparam int CH_CAN1_RX = 5;
    localparam int CH_CAN0_TX = 6;
    localparam int CH_CAN0_RX = 7;
    localparam int CH_C1_Z = 8;
    localparam int CH_C0_A = 13;
    // channels that may drive a pin
    localparam logic [13:0] DRIVE_MASK = 14'h0059;

    // ****************************************
    // register layouts
    // ****************************************
    typedef struct packed {
        logic [1:0] serial4_dataout_pin_sel;
        logic [1:0] serial4_datain_pin_sel;
        logic [1:0] serial4_cleartosend_pin_sel;
        logic [1:0] serial4_reqtosend_pin_sel;
    } pprs_serial4_t;

    typedef struct packed {
        logic [1:0] can1_transmit_pin_sel;
        logic [1:0] can1_receive_pin_sel;
        logic [1:0] can0_transmit_pin_sel;
        logic [1:0] can0_receive_pin_sel;
        logic [3:0] adc2_trigger_pin_sel;
        logic [3:0] adc1_trigger_pin_sel;
        logic [3:0] adc0_trigger_pin_sel;
        logic [1:0] counter1_zphase_pin_sel;
        logic [1:0] counter1_bphase_pin_sel;
        logic [1:0] counter1_aphase_pin_sel;
        logic [1:0] counter0_zphase_pin_sel;
        logic [1:0] counter0_bphase_pin_sel;
        logic [1:0] counter0_aphase_pin_sel;
    } pprs_route_t;

    localparam pprs_serial4_t SERIAL4_RESET = 8'h00;
    localparam pprs_route_t ROUTE_RESET = 32'h0000_0000;

    typedef struct packed {
        pprs_serial4_t serial4;
        pprs_route_t route;
        logic [31:0] prdata;
        logic pslverr;
    } pprs_state_t;
endpackage : pprs_pkg

// [logic/pprs_alt3.sv]
`timescale 1ns/100ps
`default_nettype none
module pprs_alt3 (
    input wire logic [1:0] sel,
    input wire logic drives,
    input wire logic periph_out,
    input wire logic [pprs_pkg::ALT_PINS-1:0] pin_in,
    output logic periph_in,
    output logic [pprs_pkg::ALT_PINS-1:0] pin_out,
    output logic [pprs_pkg::ALT_PINS-1:0] pin_oe
);
    logic [1:0] idx;

    always_comb
    begin
        // 00 and 01 alias pin 0
        idx = (sel == 2'h0) ? 2'h0 : sel - 2'h1;
        periph_in = pin_in[idx];
        pin_oe = '0;
        if (drives && sel != 2'h0)
        begin
            pin_oe[idx] = 1'b1;
        end
        // undriven pins rest low so nothing floats into the pad ring
        pin_out = pin_oe & {pprs_pkg::ALT_PINS{periph_out}};
    end
endmodule : pprs_alt3
`default_nettype wire

// [logic/pprs_route.sv]
`timescale 1ns/100ps
`default_nettype none
module pprs_route (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic deep_standby_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pprs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [pprs_pkg::NUM_CH-1:0] periph_out,
    output logic [pprs_pkg::NUM_CH-1:0] periph_in,
    input wire logic [pprs_pkg::NUM_CH-1:0][pprs_pkg::ALT_PINS-1:0] route_pin_in,
    output logic [pprs_pkg::NUM_CH-1:0][pprs_pkg::ALT_PINS-1:0] route_pin_out,
    output logic [pprs_pkg::NUM_CH-1:0][pprs_pkg::ALT_PINS-1:0] route_pin_oe,
    input wire logic [pprs_pkg::NUM_TRIG-1:0] adc_trigger_pin,
    output logic [pprs_pkg::NUM_ADC-1:0] adc_trigger
);
    // ****************************************
    // state
    // ****************************************
    pprs_pkg::pprs_state_t st;
    pprs_pkg::pprs_state_t next_st;

    logic setup;
    logic access;
    logic hit_serial;
    logic hit_route;
    logic [pprs_pkg::NUM_CH-1:0][1:0] ch_sel;
    logic [pprs_pkg::NUM_ADC-1:0][3:0] adc_sel;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_serial = paddr == pprs_pkg::SERIAL4_OFFSET;
    assign hit_route = paddr == pprs_pkg::ROUTE_OFFSET;

    // ****************************************
    // apb slave
    // ****************************************
    // zero wait states: read data is caught in the setup cycle,
    // so it stays a flip-flop output without costing a cycle
    assign pready = 1'b1;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr && access;

    always_comb
    begin
        next_st = st;
        if (setup)
        begin
            next_st.pslverr = !(hit_serial || hit_route);
            next_st.prdata = 32'h0000_0000;
            if (hit_serial)
            begin
                next_st.prdata[7:0] = st.serial4;
            end
            if (hit_route)
            begin
                next_st.prdata = st.route;
            end
        end
        if (access && pwrite && hit_serial && pstrb[0])
        begin
            next_st.serial4 = pwdata[7:0];
        end
        if (access && pwrite && hit_route)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (pstrb[b])
                begin
                    next_st.route[b*8 +: 8] = pwdata[b*8 +: 8];
                end
            end
        end
        // deep standby clears only the route register
        if (deep_standby_reset)
        begin
            next_st.route = pprs_pkg::ROUTE_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '{serial4: pprs_pkg::SERIAL4_RESET,
                    route: pprs_pkg::ROUTE_RESET,
                    prdata: 32'h0000_0000,
                    pslverr: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // two-bit pin selectors
    // ****************************************
    assign ch_sel = {st.route.counter0_aphase_pin_sel,
                     st.route.counter0_bphase_pin_sel,
                     st.route.counter0_zphase_pin_sel,
                     st.route.counter1_aphase_pin_sel,
                     st.route.counter1_bphase_pin_sel,
                     st.route.counter1_zphase_pin_sel,
                     st.route.can0_receive_pin_sel,
                     st.route.can0_transmit_pin_sel,
                     st.route.can1_receive_pin_sel,
                     st.route.can1_transmit_pin_sel,
                     st.serial4.serial4_reqtosend_pin_sel,
                     st.serial4.serial4_cleartosend_pin_sel,
                     st.serial4.serial4_datain_pin_sel,
                     st.serial4.serial4_dataout_pin_sel};

    genvar c;
    generate
        for (c = 0; c < pprs_pkg::NUM_CH; c++)
        begin : g_ch
            pprs_alt3 u_sel (
                .sel(ch_sel[c]),
                .drives(pprs_pkg::DRIVE_MASK[c]),
                .periph_out(periph_out[c]),
                .pin_in(route_pin_in[c]),
                .periph_in(periph_in[c]),
                .pin_out(route_pin_out[c]),
                .pin_oe(route_pin_oe[c])
            );
        end
    endgenerate

    // ****************************************
    // adc trigger selectors
    // ****************************************
    assign adc_sel = {st.route.adc2_trigger_pin_sel,
                      st.route.adc1_trigger_pin_sel,
                      st.route.adc0_trigger_pin_sel};

    genvar a;
    generate
        for (a = 0; a < pprs_pkg::NUM_ADC; a++)
        begin : g_adc
            always_comb
            begin
                // 0000 and 0001 share pin 0
                if (adc_sel[a] <= 4'h1)
                begin
                    adc_trigger[a] = adc_trigger_pin[0];
                end
                else if (adc_sel[a] <= pprs_pkg::TRIG_MAX_CODE)
                begin
                    adc_trigger[a] = adc_trigger_pin[adc_sel[a] - 4'h1];
                end
                else
                begin
                    adc_trigger[a] = 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_SOT_IDLE: assert property (
        st.serial4.serial4_dataout_pin_sel == 2'h0
        |-> route_pin_oe[pprs_pkg::CH_SOT] == 3'h0
            && periph_in[pprs_pkg::CH_SOT] == route_pin_in[pprs_pkg::CH_SOT][0])
    else $error("data-out pin driven at code 00");

    AST_SOT_PIN2: assert property (
        st.serial4.serial4_dataout_pin_sel == 2'h3
        |-> route_pin_oe[pprs_pkg::CH_SOT] == 3'h4
            && route_pin_out[pprs_pkg::CH_SOT][2] == periph_out[pprs_pkg::CH_SOT])
    else $error("data-out not on pin 2 at code 11");

    AST_SIN_ALIAS: assert property (
        st.serial4.serial4_datain_pin_sel == 2'h1
        |-> periph_in[pprs_pkg::CH_SIN] == route_pin_in[pprs_pkg::CH_SIN][0])
    else $error("data-in code 01 not on pin 0");

    AST_CTS_PIN2: assert property (
        st.serial4.serial4_cleartosend_pin_sel == 2'h3
        |-> periph_in[pprs_pkg::CH_CTS] == route_pin_in[pprs_pkg::CH_CTS][2])
    else $error("clear-to-send code 11 not on pin 2");

    AST_RTS_SEL: assert property (
        route_pin_oe[pprs_pkg::CH_RTS] ==
        ((st.serial4.serial4_reqtosend_pin_sel == 2'h0) ? 3'h0 :
         (3'h1 << (st.serial4.serial4_reqtosend_pin_sel - 2'h1))))
    else $error("request-to-send enable wrong");

    AST_WRITE_BACK: assert property (
        access && pwrite && hit_route && pstrb == 4'hF && !deep_standby_reset
        ##1 psel && !penable && !pwrite && paddr == pprs_pkg::ROUTE_OFFSET
        |=> prdata == $past(pwdata, 2))
    else $error("route register read-back mismatch");

    AST_READ_QUIET: assert property (
        access && !pwrite && !deep_standby_reset
        |=> $stable(st.route) && $stable(st.serial4))
    else $error("read disturbed routing");

    AST_DSTBY_KEEP: assert property (
        deep_standby_reset && !(access && pwrite)
        |=> $stable(st.serial4) && st.route == pprs_pkg::ROUTE_RESET)
    else $error("deep standby handling wrong");

    AST_CAN_IDLE: assert property (
        st.route == pprs_pkg::ROUTE_RESET
        |-> route_pin_oe[pprs_pkg::CH_CAN1_TX] == 3'h0
            && route_pin_oe[pprs_pkg::CH_CAN0_TX] == 3'h0
            && adc_trigger == {3{adc_trigger_pin[0]}})
    else $error("cleared register not idle");

    AST_CAN1_TX: assert property (
        st.route.can1_transmit_pin_sel == 2'h1
        |-> route_pin_oe[pprs_pkg::CH_CAN1_TX] == 3'h1)
    else $error("can 1 transmit not on pin 0");

    AST_CAN_RX: assert property (
        st.route.can1_receive_pin_sel == 2'h2
        |-> periph_in[pprs_pkg::CH_CAN1_RX] == route_pin_in[pprs_pkg::CH_CAN1_RX][1])
    else $error("can 1 receive not on pin 1");

    AST_CAN0_TX: assert property (
        st.route.can0_transmit_pin_sel == 2'h2
        |-> route_pin_oe[pprs_pkg::CH_CAN0_TX] == 3'h2)
    else $error("can 0 transmit not on pin 1");

    AST_CAN0_RX: assert property (
        st.route.can0_receive_pin_sel == 2'h3
        |-> periph_in[pprs_pkg::CH_CAN0_RX] == route_pin_in[pprs_pkg::CH_CAN0_RX][2])
    else $error("can 0 receive not on pin 2");

    AST_ADC2_PIN: assert property (
        st.route.adc2_trigger_pin_sel == 4'h9
        |-> adc_trigger[2] == adc_trigger_pin[8])
    else $error("adc 2 code 1001 not on pin 8");

    AST_ADC0_PIN: assert property (
        st.route.adc0_trigger_pin_sel == 4'h2
        |-> adc_trigger[0] == adc_trigger_pin[1])
    else $error("adc 0 code 0010 not on pin 1");

    AST_CNT_PIN: assert property (
        st.route.counter0_aphase_pin_sel == 2'h2
        |-> periph_in[pprs_pkg::CH_C0_A] == route_pin_in[pprs_pkg::CH_C0_A][1]
            && route_pin_oe[pprs_pkg::CH_C0_A] == 3'h0)
    else $error("counter phase routing wrong");

    AST_ADC_FORBID: assert property (
        st.route.adc1_trigger_pin_sel > pprs_pkg::TRIG_MAX_CODE
        |-> !adc_trigger[1])
    else $error("forbidden trigger code not idle");

    AST_SOT_PIN0: assert property (
        st.serial4.serial4_dataout_pin_sel == 2'h1
        |-> route_pin_oe[pprs_pkg::CH_SOT] == 3'h1
            && periph_in[pprs_pkg::CH_SOT] == route_pin_in[pprs_pkg::CH_SOT][0])
    else $error("data-out code 01 not on pin 0");

    AST_SIN_PIN1: assert property (
        st.serial4.serial4_datain_pin_sel == 2'h2
        |-> periph_in[pprs_pkg::CH_SIN] == route_pin_in[pprs_pkg::CH_SIN][1])
    else $error("data-in code 10 not on pin 1");

    AST_SIN_PIN2: assert property (
        st.serial4.serial4_datain_pin_sel == 2'h3
        |-> periph_in[pprs_pkg::CH_SIN] == route_pin_in[pprs_pkg::CH_SIN][2])
    else $error("data-in code 11 not on pin 2");

    AST_CTS_ALIAS: assert property (
        st.serial4.serial4_cleartosend_pin_sel <= 2'h1
        |-> periph_in[pprs_pkg::CH_CTS] == route_pin_in[pprs_pkg::CH_CTS][0])
    else $error("clear-to-send low codes not on pin 0");

    AST_RTS_OUT: assert property (
        route_pin_out[pprs_pkg::CH_RTS]
        == (route_pin_oe[pprs_pkg::CH_RTS] & {3{periph_out[pprs_pkg::CH_RTS]}}))
    else $error("request-to-send level not on its pin");

    AST_SERIAL_HIGH: assert property (
        access && !pwrite && hit_serial
        |-> prdata[31:8] == 24'h00_0000)
    else $error("serial register upper bits not zero");

    AST_CAN1_TX3: assert property (
        st.route.can1_transmit_pin_sel == 2'h3
        |-> route_pin_oe[pprs_pkg::CH_CAN1_TX] == 3'h4
            && route_pin_out[pprs_pkg::CH_CAN1_TX][2] == periph_out[pprs_pkg::CH_CAN1_TX])
    else $error("can 1 transmit not on pin 2");

    AST_CAN1_RX_ALIAS: assert property (
        st.route.can1_receive_pin_sel <= 2'h1
        |-> periph_in[pprs_pkg::CH_CAN1_RX] == route_pin_in[pprs_pkg::CH_CAN1_RX][0])
    else $error("can 1 receive low codes not on pin 0");

    AST_CAN0_TX_OFF: assert property (
        st.route.can0_transmit_pin_sel == 2'h0
        |-> route_pin_oe[pprs_pkg::CH_CAN0_TX] == 3'h0)
    else $error("can 0 transmit driven at code 00");

    AST_CAN0_RX_ALIAS: assert property (
        st.route.can0_receive_pin_sel == 2'h1
        |-> periph_in[pprs_pkg::CH_CAN0_RX] == route_pin_in[pprs_pkg::CH_CAN0_RX][0])
    else $error("can 0 receive code 01 not on pin 0");

    AST_ADC2_ALIAS: assert property (
        st.route.adc2_trigger_pin_sel == 4'h1
        |-> adc_trigger[2] == adc_trigger_pin[0])
    else $error("adc 2 code 0001 not on pin 0");

    AST_ADC1_PIN: assert property (
        st.route.adc1_trigger_pin_sel == 4'h5
        |-> adc_trigger[1] == adc_trigger_pin[4])
    else $error("adc 1 code 0101 not on pin 4");

    AST_CNT1_Z: assert property (
        st.route.counter1_zphase_pin_sel == 2'h3
        |-> periph_in[pprs_pkg::CH_C1_Z] == route_pin_in[pprs_pkg::CH_C1_Z][2]
            && route_pin_oe[pprs_pkg::CH_C1_Z] == 3'h0)
    else $error("counter 1 z phase not on pin 2");

    AST_CNT1_A: assert property (
        st.route.counter1_aphase_pin_sel == 2'h2
        |-> periph_in[pprs_pkg::CH_C1_Z + 2] == route_pin_in[pprs_pkg::CH_C1_Z + 2][1])
    else $error("counter 1 a phase not on pin 1");

    AST_NODRIVE: assert property (
        route_pin_oe[pprs_pkg::CH_SIN] == 3'h0 && route_pin_oe[pprs_pkg::CH_CTS] == 3'h0
        && route_pin_oe[pprs_pkg::CH_CAN1_RX] == 3'h0 && route_pin_oe[pprs_pkg::CH_CAN0_RX] == 3'h0
        && route_pin_oe[pprs_pkg::CH_C1_Z] == 3'h0 && route_pin_oe[pprs_pkg::CH_C0_A] == 3'h0)
    else $error("input-only channel drives a pin");

    AST_ADC0_FORBID: assert property (
        st.route.adc0_trigger_pin_sel > pprs_pkg::TRIG_MAX_CODE
        |-> !adc_trigger[0])
    else $error("adc 0 forbidden code not idle");

    AST_ADC2_FORBID: assert property (
        st.route.adc2_trigger_pin_sel > pprs_pkg::TRIG_MAX_CODE
        |-> !adc_trigger[2])
    else $error("adc 2 forbidden code not idle");
endmodule : pprs_route
`default_nettype wire

// [bench/pprs_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// peripherals and pads beside the mux
// ****************************************
module pprs_far_model (
    input wire logic pclk,
    input wire logic presetn,
    output logic [pprs_pkg::NUM_CH-1:0] periph_out,
    output logic [pprs_pkg::NUM_CH-1:0][pprs_pkg::ALT_PINS-1:0] route_pin_in,
    output logic [pprs_pkg::NUM_TRIG-1:0] adc_trigger_pin
);
    logic [63:0] lfsr;

    // every level shifts along the lfsr each cycle, so a wrongly chosen pin cannot hide behind a steady value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lfsr <= 64'h0123_4567_89AB_CDEF;
        end
        else
        begin
            lfsr <= {lfsr[62:0], lfsr[63] ^ lfsr[62] ^ lfsr[60] ^ lfsr[59]};
        end
    end

    assign periph_out = lfsr[13:0];
    assign route_pin_in = lfsr[55:14];
    assign adc_trigger_pin = lfsr[63:55] ^ lfsr[8:0];
endmodule : pprs_far_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic deep_standby_reset = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [13:0] periph_out;
    logic [13:0] periph_in;
    logic [13:0][2:0] route_pin_in;
    logic [13:0][2:0] route_pin_out;
    logic [13:0][2:0] route_pin_oe;
    logic [8:0] adc_trigger_pin;
    logic [2:0] adc_trigger;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic er;

    always #5 pclk = ~pclk;

    pprs_route dut_u (
        .pclk(pclk), .presetn(presetn), .deep_standby_reset(deep_standby_reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .periph_out(periph_out), .periph_in(periph_in),
        .route_pin_in(route_pin_in), .route_pin_out(route_pin_out),
        .route_pin_oe(route_pin_oe), .adc_trigger_pin(adc_trigger_pin),
        .adc_trigger(adc_trigger)
    );

    pprs_far_model far_u (
        .pclk(pclk), .presetn(presetn), .periph_out(periph_out),
        .route_pin_in(route_pin_in), .adc_trigger_pin(adc_trigger_pin)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (err_total == 0 && checks_done > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // one apb transfer; read data and error land in rd and er
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // sampled on falling edges, where the pass-through mux has settled
    task automatic check_ch(input int ch, input logic [1:0] c, input logic drv, input logic rcv);
        logic [2:0] oe;
        int p;
        p = (c < 2) ? 0 : c - 1;
        oe = (drv && c != 0) ? 3'h1 << (c - 1) : 3'h0;
        repeat (3)
        begin
            @(negedge pclk);
            if (rcv)
            begin
                check(periph_in[ch], route_pin_in[ch][p]);
            end
            check(route_pin_oe[ch], oe);
            check(route_pin_out[ch], oe & {3{periph_out[ch]}});
        end
    endtask : check_ch

    // ****************************************
    // scenarios
    // ****************************************
    task automatic serial_fields();
        logic [7:0] w;
        for (int i = 0; i < 4; i++)
        begin
            w = {2'(i), 2'(i + 1), 2'(i + 2), 2'(i + 3)};
            apb(1'h1, pprs_pkg::SERIAL4_OFFSET, {24'h0, w});
            check_ch(0, w[7:6], 1'h1, 1'h1);
            check_ch(1, w[5:4], 1'h0, 1'h1);
            check_ch(2, w[3:2], 1'h0, 1'h1);
            check_ch(3, w[1:0], 1'h1, 1'h0);
            apb(1'h0, pprs_pkg::SERIAL4_OFFSET, 32'h0);
            check(rd, {24'h0, w});
        end
    endtask : serial_fields

    // forbidden trigger codes are written on purpose to see the trigger held low
    task automatic route_fields();
        logic [1:0] q [10];
        logic [3:0] a [3];
        logic [31:0] w;
        logic t;
        for (int i = 0; i < 16; i++)
        begin
            foreach (q[k])
                q[k] = 2'(i + k);
            foreach (a[k])
                a[k] = 4'(i + k);
            w = {q[0], q[1], q[2], q[3], a[2], a[1], a[0], q[4], q[5], q[6], q[7], q[8], q[9]};
            apb(1'h1, pprs_pkg::ROUTE_OFFSET, w);
            check_ch(4, q[0], 1'h1, 1'h0);
            check_ch(5, q[1], 1'h0, 1'h1);
            check_ch(6, q[2], 1'h1, 1'h0);
            check_ch(7, q[3], 1'h0, 1'h1);
            for (int k = 4; k < 10; k++)
            begin
                check_ch(k + 4, q[k], 1'h0, 1'h1);
            end
            foreach (a[u])
            begin
                t = (a[u] > 9) ? 1'h0 : adc_trigger_pin[(a[u] < 2) ? 0 : a[u] - 1];
                check(adc_trigger[u], t);
            end
            apb(1'h0, pprs_pkg::ROUTE_OFFSET, 32'h0);
            check(rd, w);
        end
    endtask : route_fields

    task automatic standby_and_reset();
        apb(1'h1, pprs_pkg::SERIAL4_OFFSET, 32'hC6);
        apb(1'h1, pprs_pkg::ROUTE_OFFSET, 32'hDEAD_5713);
        @(posedge pclk);
        deep_standby_reset <= 1'h1;
        @(posedge pclk);
        deep_standby_reset <= 1'h0;
        apb(1'h0, pprs_pkg::SERIAL4_OFFSET, 32'h0);
        check(rd, 32'hC6);
        apb(1'h0, pprs_pkg::ROUTE_OFFSET, 32'h0);
        check(rd, 32'h0);
        check_ch(4, 2'h0, 1'h1, 1'h0);
        apb(1'h1, 12'h008, 32'hFFFF_FFFF);
        check(er, 1'h1);
        apb(1'h0, pprs_pkg::SERIAL4_OFFSET, 32'h0);
        check(rd, 32'hC6);
        @(posedge pclk);
        presetn <= 1'h0;
        @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, pprs_pkg::SERIAL4_OFFSET, 32'h0);
        check(rd, 32'h0);
    endtask : standby_and_reset

    // the read's setup follows the write's access at once, then a single-byte write
    task automatic back_to_back();
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= 1'h1;
        paddr <= pprs_pkg::ROUTE_OFFSET;
        pwdata <= 32'h9A51_2468;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
        begin
            @(posedge pclk);
        end
        penable <= 1'h0;
        pwrite <= 1'h0;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        check(rd, 32'h9A51_2468);
        pstrb <= 4'h2;
        apb(1'h1, pprs_pkg::ROUTE_OFFSET, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        apb(1'h0, pprs_pkg::ROUTE_OFFSET, 32'h0);
        check(rd, 32'h9A51_FF68);
    endtask : back_to_back

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        check_ch(4, 2'h0, 1'h1, 1'h0);
        check_ch(6, 2'h0, 1'h1, 1'h0);
        apb(1'h0, pprs_pkg::ROUTE_OFFSET, 32'h0);
        check(rd, 32'h0);
        serial_fields();
        route_fields();
        back_to_back();
        standby_and_reset();
        summarize();
    end

    // the full run needs about seven hundred cycles
    initial
    begin
        #100000;
        err_total++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
